// *** lcdcm_clk_div.sv ***
// lcd clock tick derived from the real-time clock pin by 1, 2 or 4
`timescale 1ns/1ps
module lcdcm_clk_div
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic rtc_clk,
   input wire logic [1:0] div_sel,
   // output
   output logic lcd_tick
);
   // ==========================================
   // state
   logic sync1_q, sync2_q, prev_q, tick_q, tick_d;
   logic [1:0] cnt_q, cnt_d, limit;
   logic edge_seen;

   // sync chain, first stage only feeds the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= rtc_clk;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // [RL2] divide select
   always_comb
   begin
      edge_seen = sync2_q & ~prev_q;
      case (div_sel)
         lcdcm_pkg::DIV_BY1: limit = lcdcm_pkg::CNT_BY1;
         lcdcm_pkg::DIV_BY2: limit = lcdcm_pkg::CNT_BY2;
         default: limit = lcdcm_pkg::CNT_BY4; // reserved code acts as by 4
      endcase
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (edge_seen)
      begin
         if (cnt_q >= limit)
         begin
            cnt_d = 2'h0;
            tick_d = 1'b1;
         end
         else
            cnt_d = cnt_q + 2'h1;
      end
   end

   // divider registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 2'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign lcd_tick = tick_q;

   div_one_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
      edge_seen && div_sel == lcdcm_pkg::DIV_BY1 |=> lcd_tick)
      else $error("divide by one missed a tick");
endmodule // lcdcm_clk_div

// *** lcdcm_mode_sel.sv ***
// contrast control mode decode and supply path selection
`timescale 1ns/1ps
module lcdcm_mode_sel
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // mode select bits
   input wire logic reduced_drive,
   input wire logic cfg_bypass,
   input wire logic pwr_pump,
   input wire logic vbm_enable,
   // battery monitor comparator, asynchronous
   input wire logic battery_low,
   // supply path
   output lcdcm_pkg::lcdcm_mode_t mode,
   output logic pump_en,
   output logic regulate_en,
   output logic bypass_en
);
   // ==========================================
   // state
   lcdcm_pkg::lcdcm_mode_t mode_q, mode_d;
   logic low1_q, low2_q;
   logic pump_q, pump_d, reg_q, reg_d, byp_q, byp_d;

   // [RL19] two stage comparator sync
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low1_q <= 1'b0;
         low2_q <= 1'b0;
      end
      else
      begin
         low1_q <= battery_low;
         low2_q <= low1_q;
      end
   end

   // decode; reduced drive is free in modes 3 and 4 for heavy loads
   always_comb
   begin
      mode_d = lcdcm_pkg::MODE_NONE;
      // [RL9] [RL10] [RL12] [RL14] [RL16] mode decode
      if (!reduced_drive && cfg_bypass && !pwr_pump && !vbm_enable)
         mode_d = lcdcm_pkg::MODE_BYPASS;
      else if (!reduced_drive && cfg_bypass && pwr_pump && vbm_enable)
         mode_d = lcdcm_pkg::MODE_MIN_CONTRAST;
      else if (!cfg_bypass && pwr_pump && vbm_enable)
         mode_d = lcdcm_pkg::MODE_CONST_CONTRAST;
      else if (!cfg_bypass && !pwr_pump && vbm_enable)
         mode_d = lcdcm_pkg::MODE_AUTO_BYPASS;
      pump_d = 1'b0;
      reg_d = 1'b0;
      byp_d = 1'b0;
      case (mode_d)
         lcdcm_pkg::MODE_BYPASS: byp_d = 1'b1;
         // [RL11] pump on low battery
         lcdcm_pkg::MODE_MIN_CONTRAST:
         begin
            pump_d = low2_q;
            byp_d = ~low2_q;
         end
         // [RL13] pump takes over regulation
         lcdcm_pkg::MODE_CONST_CONTRAST:
         begin
            pump_d = low2_q;
            reg_d = ~low2_q;
         end
         // [RL15] pump never runs here
         lcdcm_pkg::MODE_AUTO_BYPASS:
         begin
            reg_d = ~low2_q;
            byp_d = low2_q;
         end
         default: byp_d = 1'b0; // unsupported bit mix drives nothing
      endcase
   end

   // output registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= lcdcm_pkg::MODE_NONE;
         pump_q <= 1'b0;
         reg_q <= 1'b0;
         byp_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         pump_q <= pump_d;
         reg_q <= reg_d;
         byp_q <= byp_d;
      end
   end

   assign mode = mode_q;
   assign pump_en = pump_q;
   assign regulate_en = reg_q;
   assign bypass_en = byp_q;

   auto_no_pump_a: assert property (@(posedge clk) // [RL15]
      disable iff (!rst_n)
      mode_q == lcdcm_pkg::MODE_AUTO_BYPASS |-> !pump_en)
      else $error("pump running in auto bypass");
   min_pump_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL11]
      low2_q && mode_d == lcdcm_pkg::MODE_MIN_CONTRAST |=> pump_en)
      else $error("pump not started in minimum contrast");
   const_pump_a: assert property (@(posedge clk) // [RL13]
      disable iff (!rst_n)
      low2_q && mode_d == lcdcm_pkg::MODE_CONST_CONTRAST
      |=> pump_en && !regulate_en)
      else $error("pump not started in constant contrast");
   bypass_mode_a: assert property (@(posedge clk) // [RL9]
      disable iff (!rst_n)
      !reduced_drive && cfg_bypass && !pwr_pump && !vbm_enable
      |=> bypass_en && !pump_en && !regulate_en)
      else $error("bypass mode not tracking battery");
   auto_low_byp_a: assert property (@(posedge clk) // [RL14]
      disable iff (!rst_n)
      low2_q && mode_d == lcdcm_pkg::MODE_AUTO_BYPASS
      |=> bypass_en && !regulate_en)
      else $error("auto bypass not taken on low battery");
   // a change that has passed only the first stage must not act yet
   sync_delay_a: assert property (@(posedge clk) // [RL19]
      disable iff (!rst_n)
      mode_d == lcdcm_pkg::MODE_AUTO_BYPASS && $stable(mode_d)
      && low1_q && !low2_q |=> !bypass_en)
      else $error("battery low used before sync");
   auto_sw_c: cover property (@(posedge clk) disable iff (!rst_n)
      mode_q == lcdcm_pkg::MODE_AUTO_BYPASS && $rose(bypass_en));
   pump_on_c: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(pump_en));
endmodule // lcdcm_mode_sel

// *** lcdcm_panel_model.sv ***
// segment panel model: counts the segments lit at each lcd clock tick
`timescale 1ns/1ps
module lcdcm_panel_model
(
   // clock
   input wire logic clk,
   // panel drive
   input wire logic lcd_tick,
   input wire logic [127:0] segment_on,
   input wire logic [31:0] segment_pin_en,
   input wire logic [3:0] com_en,
   // glass state seen by the eye
   output logic [7:0] lit_count
);
   int n;
   initial lit_count = 8'h00;
   // glass only refreshes on a tick; an undriven pin or idle common
   // stays dark even if its segment bit is set
   always @(posedge clk)
   begin
      if (lcd_tick === 1'b1)
      begin
         n = 0;
         for (int i = 0; i < 128; i++)
            n += segment_on[i] & segment_pin_en[i/4] & com_en[i%4];
         lit_count <= 8'(n);
      end
   end
endmodule // lcdcm_panel_model

// *** lcdcm_pkg.sv ***
// constants and types shared by the display control and contrast mode logic
package lcdcm_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] DISPLAY_CONTROL_ADDR = 8'h9D;
   localparam logic [7:0] DISPLAY_CONTROL_RESET = 8'h00;
   localparam int RSVD_BIT = 7;
   localparam int LCD_CLOCK_DIVIDE_LSB = 5;
   localparam int BLANK_BIT = 4;
   localparam int SIZE_BIT = 3;
   localparam int MUX_LSB = 1;
   localparam int BIAS_BIT = 0;
   localparam int CTRL_W = 7;
   // ==========================================
   // field encodings
   localparam logic [1:0] DIV_BY1 = 2'h0;
   localparam logic [1:0] DIV_BY2 = 2'h1;
   localparam logic [1:0] CNT_BY1 = 2'h0;
   localparam logic [1:0] CNT_BY2 = 2'h1;
   localparam logic [1:0] CNT_BY4 = 2'h3;
   localparam logic [1:0] MUX_STATIC = 2'h0;
   localparam logic [1:0] MUX_2 = 2'h1;
   localparam logic [1:0] MUX_3 = 2'h2;
   localparam logic [3:0] NIB_STATIC = 4'h1;
   localparam logic [3:0] NIB_2 = 4'h3;
   localparam logic [3:0] NIB_3 = 4'h7;
   localparam logic [3:0] NIB_4 = 4'hF;
   // ==========================================
   // panel geometry
   localparam int PINS = 32;
   localparam int SEG_W = 128;
   localparam logic [31:0] PINS_SMALL = 32'h0000FFFF;
   localparam logic [31:0] PINS_LARGE = 32'hFFFFFFFF;
   // ==========================================
   // contrast setpoint scale in millivolts
   localparam logic [15:0] CONTRAST_MIN_MV = 16'h076C;
   localparam logic [15:0] CONTRAST_SPAN_MV = 16'h071C;
   localparam logic [15:0] CONTRAST_CODES = 16'h001F;
   localparam int CONTRAST_STEP_MV = 60;
   // ==========================================
   // contrast control modes
   typedef enum logic [2:0] {
      MODE_NONE,
      MODE_BYPASS,
      MODE_MIN_CONTRAST,
      MODE_CONST_CONTRAST,
      MODE_AUTO_BYPASS
   } lcdcm_mode_t;
endpackage

// *** lcdcm_top.sv ***
// display control register, segment gating and contrast mode top level
// Overview of operation
// [RL1] software writes zero to control bit 7; it always reads zero
// [RL2] lcd clock is the rtc clock divided by 1, 2 or 4
// [RL3] blank bit set turns every segment off, else segments follow data
// [RL4] size 0 gives 16 segment pins, size 1 gives 32
// [RL5] multiplex field selects static, 2-mux, 3-mux or 4-mux drive
// [RL6] bias bit 0 gives one-third bias, 1 gives one-half bias
// [RL7] bias bit is ignored in static mode
// [RL8] contrast target spans 1.9 V to 3.72 V in about 60 mV steps
// [RL9] mode 1 bypass: supply follows battery, regulation off
// [RL10] mode 2 minimum contrast: supply from battery above threshold
// [RL11] mode 2 below threshold starts the charge pump
// [RL12] mode 3 constant contrast: regulated by resistor above threshold
// [RL13] mode 3 below threshold starts the charge pump
// [RL14] mode 4 auto bypass: regulate above threshold, bypass below
// [RL15] mode 4 never runs the charge pump
// [RL16] modes 3 and 4 accept reduced drive clear for heavy loads
// [RL17] each pin uses nibble bits set by multiplex mode, rest ignored
// [RL18] display is on only while the enable bit is set
// [RL19] battery monitor result is synchronised before mode switching
`timescale 1ns/1ps
module lcdcm_top
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // control bits kept by neighbouring registers
   input wire logic display_enable,
   input wire logic reduced_drive,
   input wire logic lcd_master_cfg_bypass,
   input wire logic lcd_power_ctrl_pump,
   input wire logic battery_monitor_ctrl_en,
   input wire logic [4:0] contrast_setpoint,
   input wire logic [127:0] segment_data,
   // analog and clock pins
   input wire logic battery_low,
   input wire logic rtc_clk,
   // panel drive
   output logic lcd_tick,
   output logic [127:0] segment_on,
   output logic [31:0] segment_pin_en,
   output logic [3:0] com_en,
   output logic bias_half,
   output logic bias_third,
   output logic [15:0] contrast_mv,
   // contrast supply path
   output lcdcm_pkg::lcdcm_mode_t contrast_mode,
   output logic pump_en,
   output logic regulate_en,
   output logic bypass_en
);
   // ==========================================
   // reset release
   logic rst1_q, rst_sync_n;

   // release is synchronised so all flops leave reset on one edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst1_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst1_q <= 1'b1;
         rst_sync_n <= rst1_q;
      end
   end

   // ==========================================
   // control register
   logic [lcdcm_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [7:0] rdata_q, rdata_d;
   logic hit;
   logic [1:0] mux_sel, div_sel;

   // decode writes and capture read data
   always_comb
   begin
      hit = (sfr_addr == lcdcm_pkg::DISPLAY_CONTROL_ADDR);
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      // [RL1] reserved top bit dropped
      if (sfr_wr && hit)
         ctrl_d = sfr_wdata[lcdcm_pkg::CTRL_W-1:0];
      // unmapped reads return zero
      if (sfr_rd)
         rdata_d = hit ? {1'b0, ctrl_q} : 8'h00;
   end

   // control and read data registers
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         ctrl_q <= lcdcm_pkg::DISPLAY_CONTROL_RESET[lcdcm_pkg::CTRL_W-1:0];
         rdata_q <= 8'h00;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   // read port and field taps
   assign sfr_rdata = rdata_q;
   assign mux_sel = ctrl_q[lcdcm_pkg::MUX_LSB +: 2];
   assign div_sel = ctrl_q[lcdcm_pkg::LCD_CLOCK_DIVIDE_LSB +: 2];

   // ==========================================
   // panel configuration
   logic [3:0] nib_mask, com_q;
   logic [31:0] pins, pin_q;
   logic half_d, third_d, half_q, third_q, show;
   logic [15:0] mv_d, mv_q;

   always_comb
   begin
      // [RL5] [RL17] commons and nibble bits per mux mode
      case (mux_sel)
         lcdcm_pkg::MUX_STATIC: nib_mask = lcdcm_pkg::NIB_STATIC;
         lcdcm_pkg::MUX_2: nib_mask = lcdcm_pkg::NIB_2;
         lcdcm_pkg::MUX_3: nib_mask = lcdcm_pkg::NIB_3;
         default: nib_mask = lcdcm_pkg::NIB_4;
      endcase
      // [RL4] pin count
      pins = ctrl_q[lcdcm_pkg::SIZE_BIT] ? lcdcm_pkg::PINS_LARGE
                                         : lcdcm_pkg::PINS_SMALL;
      // [RL6] [RL7] bias choice, none in static
      half_d = (mux_sel != lcdcm_pkg::MUX_STATIC)
               & ctrl_q[lcdcm_pkg::BIAS_BIT];
      third_d = (mux_sel != lcdcm_pkg::MUX_STATIC)
                & ~ctrl_q[lcdcm_pkg::BIAS_BIT];
      // [RL3] [RL18] blank and enable gate all segments
      show = display_enable & ~ctrl_q[lcdcm_pkg::BLANK_BIT];
      // [RL8] interpolated so the top code lands on the top voltage
      mv_d = lcdcm_pkg::CONTRAST_MIN_MV
             + (({11'h000, contrast_setpoint} * lcdcm_pkg::CONTRAST_SPAN_MV)
                / lcdcm_pkg::CONTRAST_CODES);
   end

   // ==========================================
   // per pin segment gating
   logic [127:0] seg_d, seg_q;

   genvar gi;
   generate
      for (gi = 0; gi < lcdcm_pkg::PINS; gi++)
      begin : g_pin
         // [RL17] unused nibble bits masked
         assign seg_d[gi*4 +: 4] = segment_data[gi*4 +: 4] & nib_mask
                                   & {4{pins[gi] & show}};
      end
   endgenerate

   // panel registers; outputs stay glitch free toward the pads
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         seg_q <= '0;
         pin_q <= 32'h00000000;
         com_q <= 4'h0;
         half_q <= 1'b0;
         third_q <= 1'b0;
         mv_q <= 16'h0000;
      end
      else
      begin
         seg_q <= seg_d;
         pin_q <= pins;
         com_q <= nib_mask;
         half_q <= half_d;
         third_q <= third_d;
         mv_q <= mv_d;
      end
   end

   // pads are fed straight from the flops
   assign segment_on = seg_q;
   assign segment_pin_en = pin_q;
   assign com_en = com_q;
   assign bias_half = half_q;
   assign bias_third = third_q;
   assign contrast_mv = mv_q;

   // ==========================================
   // sub blocks
   // rtc divider; its own two stages tame the pin
   lcdcm_clk_div u_div
   (
      .clk(clk),
      .rst_n(rst_sync_n),
      .rtc_clk(rtc_clk),
      .div_sel(div_sel),
      .lcd_tick(lcd_tick)
   );

   // contrast supply path selection
   lcdcm_mode_sel u_mode
   (
      .clk(clk),
      .rst_n(rst_sync_n),
      .reduced_drive(reduced_drive),
      .cfg_bypass(lcd_master_cfg_bypass),
      .pwr_pump(lcd_power_ctrl_pump),
      .vbm_enable(battery_monitor_ctrl_en),
      .battery_low(battery_low),
      .mode(contrast_mode),
      .pump_en(pump_en),
      .regulate_en(regulate_en),
      .bypass_en(bypass_en)
   );

   // ==========================================
   // register checks; outputs are registered, so most checks look one
   // edge after the cause
   rsvd_read_a: assert property (@(posedge clk) // [RL1]
      disable iff (!rst_sync_n)
      sfr_rd && hit |=> !sfr_rdata[lcdcm_pkg::RSVD_BIT])
      else $error("reserved control bit read as one");
   write_read_a: assert property (@(posedge clk) // [RL1]
      disable iff (!rst_sync_n)
      sfr_wr && hit ##1 sfr_rd && hit && !sfr_wr
      |=> sfr_rdata[6:0] == $past(sfr_wdata[6:0], 2))
      else $error("control readback differs from write");

   // ==========================================
   // panel checks
   blank_off_a: assert property (@(posedge clk) // [RL3]
      disable iff (!rst_sync_n)
      ctrl_q[lcdcm_pkg::BLANK_BIT] |=> segment_on == '0)
      else $error("segment lit while blanked");
   follow_a: assert property (@(posedge clk) // [RL3]
      disable iff (!rst_sync_n)
      show && mux_sel == 2'h3 && ctrl_q[lcdcm_pkg::SIZE_BIT]
      |=> segment_on == $past(segment_data))
      else $error("segments not following data");
   size_pins_a: assert property (@(posedge clk) // [RL4]
      disable iff (!rst_sync_n)
      !ctrl_q[lcdcm_pkg::SIZE_BIT] |=> segment_pin_en[31:16] == 16'h0000
      && segment_on[127:64] == '0)
      else $error("upper pins active in small panel");
   size_large_a: assert property (@(posedge clk) // [RL4]
      disable iff (!rst_sync_n)
      ctrl_q[lcdcm_pkg::SIZE_BIT]
      |=> segment_pin_en == lcdcm_pkg::PINS_LARGE)
      else $error("pins missing in large panel");
   four_com_a: assert property (@(posedge clk) // [RL5]
      disable iff (!rst_sync_n)
      mux_sel == 2'h3 |=> com_en == lcdcm_pkg::NIB_4)
      else $error("commons missing in four mux mode");
   // a two mux panel must never see bits 2 and 3 of a nibble
   two_mux_nib_a: assert property (@(posedge clk) // [RL17]
      disable iff (!rst_sync_n)
      show && mux_sel == lcdcm_pkg::MUX_2 && ctrl_q[lcdcm_pkg::SIZE_BIT]
      |=> segment_on == ($past(segment_data) & {32{lcdcm_pkg::NIB_2}}))
      else $error("unused nibble bit reached a segment");
   static_bias_a: assert property (@(posedge clk) // [RL7]
      disable iff (!rst_sync_n)
      mux_sel == lcdcm_pkg::MUX_STATIC |=> !bias_half && !bias_third
      && com_en == lcdcm_pkg::NIB_STATIC)
      else $error("bias active in static mode");
   bias_sel_a: assert property (@(posedge clk) // [RL6]
      disable iff (!rst_sync_n)
      mux_sel != lcdcm_pkg::MUX_STATIC
      |=> bias_half == $past(ctrl_q[lcdcm_pkg::BIAS_BIT])
      && bias_third != bias_half)
      else $error("bias ratio mismatch");
   enable_a: assert property (@(posedge clk) // [RL18]
      disable iff (!rst_sync_n)
      !display_enable |=> segment_on == '0)
      else $error("segment lit while display disabled");

   // ==========================================
   // contrast checks at both ends of the code range
   contrast_a: assert property (@(posedge clk) // [RL8]
      disable iff (!rst_sync_n)
      contrast_setpoint == 5'h1F |=> contrast_mv == 16'h0E88)
      else $error("top contrast code not at top voltage");
   contrast_low_a: assert property (@(posedge clk) // [RL8]
      disable iff (!rst_sync_n)
      contrast_setpoint == 5'h00
      |=> contrast_mv == lcdcm_pkg::CONTRAST_MIN_MV)
      else $error("lowest contrast code not at bottom voltage");

   // ==========================================
   // main scenarios reached
   blank_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
      $rose(ctrl_q[lcdcm_pkg::BLANK_BIT]));
   four_mux_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
      show && com_en == lcdcm_pkg::NIB_4 && segment_on != '0);
   tick_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
      lcd_tick && div_sel == lcdcm_pkg::DIV_BY2);
endmodule // lcdcm_top

// *** lcdcm_top_tb_top.sv ***
// self-checking testbench for the display control and contrast modes
`timescale 1ns/1ps
module lcdcm_top_tb_top;
   // ==========================================
   // signals
   logic clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv;
   logic display_enable = 1'b1, reduced_drive = 1'b0, cfg = 1'b0;
   logic pwr = 1'b0, vbm = 1'b0, battery_low = 1'b0, rtc_clk = 1'b0;
   logic [4:0] contrast_setpoint = 5'h00;
   logic [127:0] segment_data = 128'h0, segment_on;
   logic [31:0] segment_pin_en;
   logic [3:0] com_en, mk;
   logic bias_half, bias_third, lcd_tick, pump_en, regulate_en;
   logic bypass_en;
   logic [15:0] contrast_mv;
   logic [7:0] lit_count;
   lcdcm_pkg::lcdcm_mode_t contrast_mode;
   int err_count = 0, n_checks = 0, cyc = 0, ticks = 0;
   // mode table: {reduced, cfg, pwr, vbm, low} -> {mode, pump, reg, byp}
   logic [4:0] ms [10] = '{5'h08, 5'h09, 5'h18, 5'h0E, 5'h0F,
                          5'h16, 5'h07, 5'h02, 5'h13, 5'h0A};
   logic [5:0] me [10] = '{{lcdcm_pkg::MODE_BYPASS, 3'h1},
      {lcdcm_pkg::MODE_BYPASS, 3'h1}, {lcdcm_pkg::MODE_NONE, 3'h0},
      {lcdcm_pkg::MODE_MIN_CONTRAST, 3'h1},
      {lcdcm_pkg::MODE_MIN_CONTRAST, 3'h4},
      {lcdcm_pkg::MODE_CONST_CONTRAST, 3'h2},
      {lcdcm_pkg::MODE_CONST_CONTRAST, 3'h4},
      {lcdcm_pkg::MODE_AUTO_BYPASS, 3'h2},
      {lcdcm_pkg::MODE_AUTO_BYPASS, 3'h1}, {lcdcm_pkg::MODE_NONE, 3'h0}};
   // ==========================================
   // design and panel
   lcdcm_top u_lcdcm_top (.clk(clk), .rst_n(rst_n),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .display_enable(display_enable), .reduced_drive(reduced_drive),
      .lcd_master_cfg_bypass(cfg), .lcd_power_ctrl_pump(pwr),
      .battery_monitor_ctrl_en(vbm),
      .contrast_setpoint(contrast_setpoint),
      .segment_data(segment_data), .battery_low(battery_low),
      .rtc_clk(rtc_clk), .lcd_tick(lcd_tick), .segment_on(segment_on),
      .segment_pin_en(segment_pin_en), .com_en(com_en),
      .bias_half(bias_half), .bias_third(bias_third),
      .contrast_mv(contrast_mv), .contrast_mode(contrast_mode),
      .pump_en(pump_en), .regulate_en(regulate_en),
      .bypass_en(bypass_en));
   lcdcm_panel_model u_lcdcm_panel_model (.clk(clk),
      .lcd_tick(lcd_tick), .segment_on(segment_on),
      .segment_pin_en(segment_pin_en), .com_en(com_en),
      .lit_count(lit_count));
   // ==========================================
   // clock, tick count and hang guard
   always #5 clk = ~clk;
   // ceiling is about nine times the expected run of about 850 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (lcd_tick === 1'b1)
         ticks++;
      if (cyc == 8000)
      begin
         err_count++;
         test_done();
      end
   end
   // ==========================================
   // tasks
   task test_done();
      if (err_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [127:0] s, input logic [127:0] e);
      n_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %0h want %0h", $time, s, e);
      end
   endtask
   // one-cycle strobe, then an idle cycle so strobes never merge
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      @(negedge clk);
   endtask
   // read data is registered, so sample once it has settled
   task rd(input logic [7:0] a);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      repeat (2) @(negedge clk);
      rv = sfr_rdata;
   endtask
   task ctl(input logic [1:0] dv, input logic bl, input logic sz,
            input logic [1:0] mx, input logic bs);
      wr(lcdcm_pkg::DISPLAY_CONTROL_ADDR, {1'b0, dv, bl, sz, mx, bs});
      repeat (4) @(negedge clk);
   endtask
   task rtc_run(input int n);
      repeat (n)
      begin
         rtc_clk = 1'b1;
         repeat (4) @(negedge clk);
         rtc_clk = 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask
   function automatic logic [127:0] seg(input logic [3:0] m,
      input logic sz, input logic [127:0] d);
      logic [127:0] r;
      r = '0;
      for (int i = 0; i < 32; i++)
         if (i < 16 || sz)
            r[4*i+:4] = d[4*i+:4] & m;
      return r;
   endfunction
   // ==========================================
   // main sequence
   initial
   begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      // register reset value, reserved bit, unmapped place
      rd(lcdcm_pkg::DISPLAY_CONTROL_ADDR);
      chk(rv, 8'h00);
      wr(lcdcm_pkg::DISPLAY_CONTROL_ADDR, 8'h7F);
      wr(8'h9C, 8'h00);
      rd(lcdcm_pkg::DISPLAY_CONTROL_ADDR);
      chk(rv, 8'h7F);
      rd(8'h9C);
      chk(rv, 8'h00);
      // write, then read on the very next edge
      sfr_addr = lcdcm_pkg::DISPLAY_CONTROL_ADDR;
      sfr_wdata = 8'h5E;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      chk(sfr_rdata, 8'h5E);
      // every mux, size and bias setting against one data pattern
      segment_data = {8{16'h5AC3}};
      for (int m = 0; m < 4; m++)
         for (int s = 0; s < 2; s++)
            for (int b = 0; b < 2; b++)
            begin
               ctl(2'h0, 1'b0, s[0], m[1:0], b[0]);
               mk = 4'((5'h1 << (m + 1)) - 5'h1);
               chk(segment_on, seg(mk, s[0], segment_data));
               chk(segment_pin_en, s ? 32'hFFFFFFFF : 32'h0000FFFF);
               chk(com_en, mk);
               chk(bias_half, m && b[0]);
               chk(bias_third, m && !b[0]);
            end
      ctl(2'h0, 1'b1, 1'b1, 2'h3, 1'b0);
      chk(segment_on, 128'h0);
      ctl(2'h0, 1'b0, 1'b1, 2'h3, 1'b0);
      display_enable = 1'b0;
      repeat (3) @(negedge clk);
      chk(segment_on, 128'h0);
      display_enable = 1'b1;
      // contrast codes across the span, endpoints included
      foreach (ms[i])
      begin
         contrast_setpoint = 5'(i * 31 / 9);
         repeat (3) @(negedge clk);
         chk(contrast_mv, 16'(1900 + (i * 31 / 9) * 1820 / 31));
      end
      // each of the four modes with the battery high and low, plus two unsupported bit mixes
      foreach (ms[i])
      begin
         {reduced_drive, cfg, pwr, vbm, battery_low} = ms[i];
         repeat (6) @(negedge clk);
         chk(contrast_mode, me[i][5:3]);
         chk(pump_en, me[i][2]);
         chk({regulate_en, bypass_en}, me[i][1:0]);
      end
      // battery drop in mode 2 must pass a two-stage synchroniser
      {reduced_drive, cfg, pwr, vbm, battery_low} = 5'h0E;
      repeat (6) @(negedge clk);
      battery_low = 1'b1;
      repeat (2) @(negedge clk);
      chk(pump_en, 1'b0);
      repeat (2) @(negedge clk);
      chk(pump_en, 1'b1);
      // divider settings, reserved code acts as divide by four
      segment_data = '1;
      for (int d = 0; d < 4; d++)
      begin
         ctl(d[1:0], 1'b0, 1'b1, 2'h3, 1'b0);
         repeat (10) @(negedge clk);
         ticks = 0;
         rtc_run(16);
         repeat (6) @(negedge clk);
         chk(ticks, d == 0 ? 16 : (d == 1 ? 8 : 4));
      end
      chk(lit_count, 8'h80);
      test_done();
   end
endmodule // lcdcm_top_tb_top
